// file: src/coil_consts.svh
// Timing counts and thresholds for the coil driver turn-on and thermal logic.
// Assumes a 100 MHz system clock and an oscillator that arrives as a squared pin level.
//
// Notes on behaviour
// - Static high, open or supply-shorted input forces output low immediately.
// - Static low input switches output off after two to six oscillator periods.
// - After turn-on, output is the inverse of the input PWM level.
// - Undervoltage or over-temperature clamps the control input low while it lasts.
// - Squared oscillator divided by four clocks the PWM analysis.
// - Oscillator runs 50 to 5000 Hz; turn-on and turn-off delays count oscillator periods.
// - Setpoint pin at ground disables thermal fault entirely.
// - Setpoint pin open forces output low as emergency cut-out.
// - Over-temperature low is captured into scratch pad 200 ns before output rise.
// - Next output rising edge moves scratch pad low into the fault latch.
// - Comparator returning high resets scratch pad and fault latch.
// - In standby or fault report, oscillator rising edges clock scratch pad and latch.
// - Input toggling above 0.6 oscillator frequency sets turn-on after 2-6 periods.
// - Input toggling below 0.2 oscillator frequency clears turn-on after 2-6 periods.
// - Control input is active low; unconnected reads as high.
// - Both undervoltage lockouts ANDed; losing either drives output low and resets logic.
`ifndef COIL_CONSTS_SVH
`define COIL_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define SCRATCH_LEAD_NS 200
`define SCRATCH_LEAD_CYC ((`SCRATCH_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Input edges are counted per window of two oscillator periods, closed by each
// edge of the quarter-rate clock.
// Toggle above 0.6 oscillator frequency puts at least two edges into every window.
`define ON_MIN_EDGES 2'h2
// Toggle below 0.2 oscillator frequency puts at most one edge into a window.
`define OFF_MAX_EDGES 2'h1
`define EDGE_CNT_MAX 2'h3

`endif

// file: src/coil_pkg.sv
// Types shared by the coil driver logic.
// Assumes coil_consts.svh is included where counts are needed.
package coil_pkg;
    typedef enum logic [1:0] {
        SP_OPEN,
        SP_GROUND,
        SP_RESISTOR,
        SP_RESERVED
    } setpoint_t;

    typedef struct packed {
        logic vdd_ok;
        logic rail_ok;
        logic temp_ok;
    } supply_status_t;

    typedef struct packed {
        logic out_drive;
        logic ctrl_clamp_oe;
        logic ctrl_clamp_o;
    } drive_t;
endpackage

// file: src/coil_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the level may change at any time relative to clk.
`timescale 1ns/1ps
module coil_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1 = rst ? RESET_VAL : async_in;
        next_sync_out = rst ? RESET_VAL : stage1;
    end

    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule

// file: src/coil_driver_logic.sv
// Turn-on/off, PWM pass-through and thermal filter of a coil driver.
// Assumes all pins are asynchronous, the oscillator arrives squared, and the
// setpoint pin state is decoded by the analog front end into two levels.
`timescale 1ns/1ps
`include "coil_consts.svh"
module coil_driver_logic (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control input pin, active low; open reads high
    input wire logic ctrl_in_n,
    output logic ctrl_clamp_o,
    output logic ctrl_clamp_oe,
    // Oscillator and analog status
    input wire logic osc_square,
    input wire coil_pkg::supply_status_t status_pin,
    input wire logic setpoint_open,
    input wire logic setpoint_ground,
    // Output drive and status
    output logic out_drive,
    output logic turn_on_state,
    output logic fault_latch
);
    import coil_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic in_s, osc_s, vdd_s, rail_s, temp_s, spo_s, spg_s;
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_v, sync_v;
    // Reset values match the idle pin levels, so no false edge or lockout follows reset
    localparam logic [NSYNC-1:0] SYNC_RST = 7'h5C;
    assign raw_v = {ctrl_in_n, osc_square, status_pin.vdd_ok, status_pin.rail_ok,
                    status_pin.temp_ok, setpoint_open, setpoint_ground};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            coil_sync2 #(.RESET_VAL(SYNC_RST[gi])) u_sync (
                .clk(clk),
                .rst(rst),
                .async_in(raw_v[gi]),
                .sync_out(sync_v[gi])
            );
        end
    endgenerate
    assign {in_s, osc_s, vdd_s, rail_s, temp_s, spo_s, spg_s} = sync_v;

    logic power_ok;
    assign power_ok = vdd_s & rail_s;
    setpoint_t setpoint;
    always_comb begin
        if (spo_s) begin
            setpoint = SP_OPEN;
        end else if (spg_s) begin
            setpoint = SP_GROUND;
        end else begin
            setpoint = SP_RESISTOR;
        end
    end

    // ----------------------------------------
    // Quarter-rate clock and input edge windows
    // ----------------------------------------
    logic osc_d, in_d, osc_rise, in_edge, htick, win_fast, win_slow;
    logic [1:0] div, cur_edges, prev_edges;
    logic [1:0] next_div, next_cur_edges, next_prev_edges;
    logic next_turn_on, next_osc_d, next_in_d;

    assign osc_rise = osc_s & ~osc_d;
    assign in_edge = in_s ^ in_d;
    // oscillator period units
    // Both edges of the quarter-rate clock close a window of two oscillator periods;
    // judging two whole windows keeps on and off delays within 2 to 6 periods.
    assign htick = osc_rise & div[0];
    assign win_fast = (cur_edges >= `ON_MIN_EDGES) && (prev_edges >= `ON_MIN_EDGES);
    assign win_slow = (cur_edges <= `OFF_MAX_EDGES) && (prev_edges <= `OFF_MAX_EDGES);

    always_comb begin
        next_osc_d = osc_s;
        next_in_d = in_s;
        next_div = osc_rise ? div + 2'h1 : div;
        next_cur_edges = cur_edges;
        next_prev_edges = prev_edges;
        next_turn_on = turn_on_state;
        if (in_edge && cur_edges != `EDGE_CNT_MAX) begin
            next_cur_edges = cur_edges + 2'h1;
        end
        if (htick) begin
            next_prev_edges = cur_edges;
            next_cur_edges = in_edge ? 2'h1 : 2'h0;
            if (win_fast) begin
                next_turn_on = 1'b1;
            end
            // static high ends turn-on; the output itself is cut at once below
            if (win_slow) begin
                next_turn_on = 1'b0;
            end
        end
        if (!power_ok) begin
            next_turn_on = 1'b0;
            next_div = 2'h0;
            next_cur_edges = 2'h0;
            next_prev_edges = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            osc_d <= 1'b0;
            in_d <= 1'b1;
            div <= 2'h0;
            cur_edges <= 2'h0;
            prev_edges <= 2'h0;
            turn_on_state <= 1'b0;
        end else begin
            osc_d <= next_osc_d;
            in_d <= next_in_d;
            div <= next_div;
            cur_edges <= next_cur_edges;
            prev_edges <= next_prev_edges;
            turn_on_state <= next_turn_on;
        end
    end

    // ----------------------------------------
    // Thermal filter and output
    // ----------------------------------------
    logic scratch, next_scratch, next_fault, next_out, out_pre, next_out_pre;
    logic [4:0] lead_cnt, next_lead_cnt;
    logic reporting, standby, temp_low, next_clamp;
    logic want_on, rise_pending, fault_clk, idle_slot;

    assign temp_low = ~temp_s & (setpoint != SP_GROUND);
    assign reporting = ctrl_clamp_oe;
    assign standby = ~turn_on_state;
    assign want_on = turn_on_state & ~in_s & power_ok & ~fault_latch & (setpoint != SP_OPEN);
    assign rise_pending = want_on & ~out_pre;

    always_comb begin
        next_out_pre = want_on;
        next_lead_cnt = lead_cnt;
        next_scratch = scratch;
        next_fault = fault_latch;
        // hold rise for the capture lead
        if (rise_pending) begin
            next_out_pre = 1'b0;
            next_lead_cnt = lead_cnt + 5'h1;
            if (lead_cnt == 5'(`SCRATCH_LEAD_CYC) - 5'h1) begin
                next_out_pre = 1'b1;
                next_lead_cnt = 5'h0;
            end
        end else begin
            next_lead_cnt = 5'h0;
        end
        fault_clk = (standby | reporting) ? osc_rise : (next_out_pre & ~out_pre);
        idle_slot = (standby | reporting) & osc_rise;
        if (temp_low && (lead_cnt == 5'h0) && (rise_pending || idle_slot)) begin
            next_scratch = 1'b1;
        end
        if (fault_clk && scratch) begin
            next_fault = 1'b1;
        end
        if (!temp_low) begin
            next_scratch = 1'b0;
            next_fault = 1'b0;
        end
        // fault overrides PWM; open cut-out; no delay
        next_out = next_out_pre & ~next_fault & power_ok & (setpoint != SP_OPEN) & ~in_s;
        next_clamp = ~power_ok | next_fault;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_pre <= 1'b0;
            lead_cnt <= 5'h0;
            scratch <= 1'b0;
            fault_latch <= 1'b0;
            out_drive <= 1'b0;
            ctrl_clamp_oe <= 1'b0;
            ctrl_clamp_o <= 1'b0;
        end else begin
            out_pre <= next_out_pre;
            lead_cnt <= next_lead_cnt;
            scratch <= next_scratch;
            fault_latch <= next_fault;
            out_drive <= next_out;
            ctrl_clamp_oe <= next_clamp;
            ctrl_clamp_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_fault_set;
        fault_latch;
    endsequence
    sequence s_fast_window;
        htick && win_fast && power_ok;
    endsequence
    sequence s_slow_window;
        htick && win_slow;
    endsequence

    a_fault_blocks_out: assert property (@(posedge clk) disable iff (rst)
        s_fault_set |=> !out_drive) else $error("output high while fault latched");
    a_clamp_on_fault: assert property (@(posedge clk) disable iff (rst)
        fault_latch |-> ctrl_clamp_oe && !ctrl_clamp_o) else $error("fault not clamped");
    a_lockout_low: assert property (@(posedge clk) disable iff (rst)
        !power_ok |=> !out_drive && !turn_on_state) else $error("output on in lockout");
    a_ground_no_fault: assert property (@(posedge clk) disable iff (rst)
        setpoint == SP_GROUND |=> !fault_latch) else $error("fault with thermal disabled");
    a_open_cut_out: assert property (@(posedge clk) disable iff (rst)
        setpoint == SP_OPEN |=> !out_drive) else $error("output on with setpoint open");
    a_high_no_delay: assert property (@(posedge clk) disable iff (rst)
        in_s |=> !out_drive) else $error("output on with input high");
    a_comp_high_reset: assert property (@(posedge clk) disable iff (rst)
        !temp_low |=> !scratch && !fault_latch) else $error("filter not reset");
    a_scratch_lead: assert property (@(posedge clk) disable iff (rst)
        $rose(out_pre) |-> $past(rise_pending, 20)) else $error("rise without lead");
    a_fast_turns_on: assert property (@(posedge clk) disable iff (rst)
        s_fast_window |=> turn_on_state) else $error("fast input did not turn on");
    a_slow_turns_off: assert property (@(posedge clk) disable iff (rst)
        s_slow_window |=> !turn_on_state) else $error("slow input did not turn off");
endmodule

// file: verif/coil_ctrl_model.sv
// External controller on the active-low control pin, with the pin resolution.
// Assumes the device may clamp the pin low and the pin has a pull-up.
`timescale 1ns/1ps
module coil_ctrl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic pwm_en,
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic [9:0] half_period,
    // Device clamp
    input wire logic clamp_oe,
    input wire logic clamp_o,
    // Resolved pin level
    output logic pin_level
);
    logic level;
    logic [9:0] cnt;
    always_ff @(posedge clk) begin
        if (rst || !pwm_en) begin
            cnt <= 10'h000;
            level <= 1'b1;
        end else if (cnt + 10'h001 >= half_period) begin
            cnt <= 10'h000;
            level <= ~level;
        end else begin
            cnt <= cnt + 10'h001;
        end
    end
    always_comb begin
        if (clamp_oe) pin_level = clamp_o;
        else if (pwm_en) pin_level = level;
        else if (drive_en) pin_level = drive_val;
        else pin_level = 1'b1;
    end
endmodule

// file: verif/tb_coil_driver_logic.sv
// Self-checking bench for the coil driver turn-on and thermal logic.
// Assumes a free-running oscillator and the controller model beside the DUT.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp, msg) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("CHECK FAILED at %0t: %s", $time, msg); \
        end \
    end
module tb_coil_driver_logic;
    import coil_pkg::*;
    // Oscillator period 200 cycles; input toggles at about 1.7 times that rate
    localparam int OSC_HALF = 100;
    localparam int LIM6 = 12 * OSC_HALF + 20;
    localparam int K_OUT = 0;
    localparam int K_ON = 1;
    localparam int K_LATCH = 2;
    localparam int K_CLAMP = 3;
    localparam int K_PIN = 4;
    logic clk, rst, osc_square, setpoint_open, setpoint_ground;
    logic pwm_en, drive_en, drive_val, ctrl_in_n, ctrl_clamp_o, ctrl_clamp_oe;
    logic out_drive, turn_on_state, fault_latch;
    supply_status_t status_pin;
    int errors = 0;
    int n_compared = 0;

    coil_driver_logic DUT (.clk(clk), .rst(rst), .ctrl_in_n(ctrl_in_n),
        .ctrl_clamp_o(ctrl_clamp_o), .ctrl_clamp_oe(ctrl_clamp_oe),
        .osc_square(osc_square), .status_pin(status_pin),
        .setpoint_open(setpoint_open), .setpoint_ground(setpoint_ground),
        .out_drive(out_drive), .turn_on_state(turn_on_state), .fault_latch(fault_latch));
    coil_ctrl_model ctrl_model (.clk(clk), .rst(rst), .pwm_en(pwm_en),
        .drive_en(drive_en), .drive_val(drive_val), .half_period(10'h03C),
        .clamp_oe(ctrl_clamp_oe), .clamp_o(ctrl_clamp_o), .pin_level(ctrl_in_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        osc_square = 1'b0;
        #3;
        forever #(OSC_HALF * 10) osc_square = ~osc_square;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic pick(input int k);
        case (k)
            K_OUT: return out_drive;
            K_ON: return turn_on_state;
            K_LATCH: return fault_latch;
            K_CLAMP: return ctrl_clamp_oe;
            default: return ctrl_in_n;
        endcase
    endfunction
    task automatic wait_sig(input int k, input logic v, input int lim, input string msg);
        int i;
        i = 0;
        while (pick(k) !== v && i < lim) begin
            step(1);
            i++;
        end
        `CHECK_EQ(pick(k), v, msg)
    endtask
    // One compare for a whole span, so long holds do not swamp the count
    task automatic hold_sig(input int k, input logic v, input int n, input string msg);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            step(1);
            if (pick(k) !== v) ok = 1'b0;
        end
        `CHECK_EQ(ok, 1'b1, msg)
    endtask
    task automatic go_on();
        pwm_en = 1'b1;
        wait_sig(K_ON, 1'b1, LIM6, "fast input turns on");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_pwm();
        go_on();
        wait_sig(K_PIN, 1'b1, 100, "input high before low phase");
        wait_sig(K_PIN, 1'b0, 200, "input low phase");
        step(40);
        `CHECK_EQ(out_drive, 1'b1, "out high on input low")
        wait_sig(K_PIN, 1'b1, 100, "input high phase");
        step(8);
        `CHECK_EQ(out_drive, 1'b0, "out low on input high")
    endtask
    task automatic t_static_high();
        pwm_en = 1'b0;
        drive_en = 1'b0;
        wait_sig(K_OUT, 1'b0, 6, "open input kills out");
        wait_sig(K_ON, 1'b0, LIM6, "static high turns off");
    endtask
    task automatic t_static_low();
        go_on();
        pwm_en = 1'b0;
        drive_en = 1'b1;
        drive_val = 1'b0;
        hold_sig(K_ON, 1'b1, 300, "no early turn-off");
        wait_sig(K_ON, 1'b0, LIM6, "static low turns off");
        wait_sig(K_OUT, 1'b0, 2, "out off after static low");
        drive_en = 1'b0;
    endtask
    task automatic t_lockout();
        for (int i = 1; i <= 2; i++) begin
            go_on();
            status_pin[i] = 1'b0;
            wait_sig(K_CLAMP, 1'b1, 6, "lockout clamps pin");
            `CHECK_EQ(ctrl_in_n, 1'b0, "pin read low")
            `CHECK_EQ(out_drive, 1'b0, "lockout out low")
            `CHECK_EQ(turn_on_state, 1'b0, "lockout resets logic")
            status_pin[i] = 1'b1;
            wait_sig(K_CLAMP, 1'b0, 6, "clamp released");
        end
    endtask
    task automatic t_thermal();
        go_on();
        status_pin.temp_ok = 1'b0;
        wait_sig(K_LATCH, 1'b1, 200, "latch at output rise");
        wait_sig(K_CLAMP, 1'b1, 4, "fault clamps pin");
        `CHECK_EQ(out_drive, 1'b0, "fault holds out low")
        status_pin.temp_ok = 1'b1;
        wait_sig(K_LATCH, 1'b0, 6, "comparator high clears");
        wait_sig(K_CLAMP, 1'b0, 6, "clamp released");
        pwm_en = 1'b0;
        wait_sig(K_ON, 1'b0, LIM6, "standby reached");
        status_pin.temp_ok = 1'b0;
        wait_sig(K_LATCH, 1'b1, 4 * OSC_HALF + 10, "standby latch on osc");
        status_pin.temp_ok = 1'b1;
        wait_sig(K_LATCH, 1'b0, 6, "standby latch cleared");
    endtask
    task automatic t_setpoint();
        setpoint_ground = 1'b1;
        go_on();
        status_pin.temp_ok = 1'b0;
        hold_sig(K_LATCH, 1'b0, 400, "grounded setpoint no fault");
        status_pin.temp_ok = 1'b1;
        setpoint_ground = 1'b0;
        setpoint_open = 1'b1;
        step(6);
        hold_sig(K_OUT, 1'b0, 300, "open setpoint cut-out");
        setpoint_open = 1'b0;
    endtask

    // ----------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        pwm_en = 1'b0;
        drive_en = 1'b0;
        drive_val = 1'b1;
        status_pin = 3'h7;
        setpoint_open = 1'b0;
        setpoint_ground = 1'b0;
        step(4);
        rst = 1'b0;
        t_pwm();
        t_static_high();
        t_static_low();
        t_lockout();
        t_thermal();
        t_setpoint();
        wrap_up();
    end
    // Whole run needs roughly 10000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule
